// [shared/bridge_cfg.svh]
`ifndef BRIDGE_CFG_SVH
`define BRIDGE_CFG_SVH

// Configuration byte offsets
`define CFG_INTPIN_OFS 8'h3d
`define CFG_BRCTL_OFS 8'h3e

// Fixed contents and reset values
`define INTPIN_VALUE 8'h00
`define INTLINE_VALUE 8'h00
`define BRCTL_RESET 16'h0000
`define BRCTL_RSVD_VALUE 4'h0

// Bridge control field positions
`define BRCTL_ERRMSG_BIT 11
`define BRCTL_DTSTAT_BIT 10
`define BRCTL_PERIOD_BIT 9

// Discard timer periods in PCI clocks
`define DT_SHORT_CLKS 16'h0400
`define DT_LONG_CLKS 16'h8000

// Structure sizes
`define DT_SLOTS 4
`define INTX_LINES 4
`define MSG_PEND_MAX 4'hf

`endif

// [shared/bridge_pkg.sv]
`include "bridge_cfg.svh"

package bridge_pkg;

	// Control state of the main block
	typedef struct packed {
		logic errmsg_en;
		logic period_sel;
		logic discard_flag;
		logic [3:0] msg_pending;
		logic msg_fatal;
		logic [31:0] rdata;
		logic rvalid;
	} ctrl_state_t;

	// State of one discard timer slot
	typedef struct packed {
		logic running;
		logic [15:0] count;
		logic expired;
	} slot_state_t;

	// Interrupt line synchroniser
	typedef struct packed {
		logic [`INTX_LINES-1:0] stage1;
		logic [`INTX_LINES-1:0] stage2;
	} sync_state_t;

endpackage : bridge_pkg

// [shared/discard_if.sv]
`timescale 1ns/1ps
`include "bridge_cfg.svh"

// Links the control block to its discard timer slots
interface discard_if;
	logic ce;
	logic [15:0] limit;
	logic start [`DT_SLOTS];
	logic stop [`DT_SLOTS];
	logic expired [`DT_SLOTS];

	modport ctrl (output ce, output limit, output start, output stop, input expired);
	modport slot (input ce, input limit, input start, input stop, output expired);
endinterface : discard_if

// [verilog/discard_slot_timer.sv]
`timescale 1ns/1ps
`include "bridge_cfg.svh"

module discard_slot_timer #(
	parameter int IDX = 0
) (
	input wire logic clk, // PCI clock
	input wire logic reset, // Async reset, active high
	discard_if.slot dif // Control link
);

	bridge_pkg::slot_state_t q;
	bridge_pkg::slot_state_t d;

	// Count toward the selected period
	always_comb
	begin
		d = q;
		d.expired = 1'b0;
		if (dif.stop[IDX])
		begin
			d.running = 1'b0;
			d.count = 16'h0000;
		end
		else if (dif.start[IDX])
		begin
			d.running = 1'b1;
			d.count = 16'h0000;
		end
		else if (q.running)
		begin
			if (q.count == dif.limit - 16'h0001)
			begin
				d.running = 1'b0;
				d.count = 16'h0000;
				d.expired = 1'b1;
			end
			else
				d.count = q.count + 16'h0001;
		end
	end

	// State register, frozen while enable is low
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			q <= '0;
		else if (dif.ce)
			q <= d;
	end

	assign dif.expired[IDX] = q.expired;

endmodule : discard_slot_timer

// [verilog/intx_sync.sv]
`timescale 1ns/1ps
`include "bridge_cfg.svh"

module intx_sync (
	input wire logic clk, // PCI clock
	input wire logic reset, // Async reset, active high
	input wire logic ce, // Clock enable
	input wire logic [`INTX_LINES-1:0] pins_n, // Secondary interrupt pins, active low
	output logic [`INTX_LINES-1:0] level // Synchronised request, active high
);

	bridge_pkg::sync_state_t q;
	bridge_pkg::sync_state_t d;

	// Two stages; the second also inverts to active high
	always_comb
	begin
		d = q;
		d.stage1 = pins_n;
		d.stage2 = ~q.stage1;
	end

	// Reset shows no pending interrupt
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			q.stage1 <= '1;
			q.stage2 <= '0;
		end
		else if (ce)
			q <= d;
	end

	assign level = q.stage2;

endmodule : intx_sync

// [verilog/bridge_discard_timer_ctrl.sv]
// Overview of operation
// - Interrupt pin byte always reads zero; the bridge raises no interrupts itself.
// - Secondary interrupt lines are forwarded to the primary side.
// - Bridge control bits 15 to 12 are reserved and read zero.
// - With message enable set, each discard queues an error message upstream, up to 15 pending.
// - Enable works only in conventional mode; severity nonfatal unless error reporting selects.
// - With enable clear, discard still signals when error reporting unmasks it.
// - Discard flag sets on every discard; software clears it by writing one.
// - Period select: zero gives 2^15 clocks, one gives 2^10; reset zero.
// - Timer starts when the delayed completion reaches the queue head.
// - On expiry before the retry, the transaction is dropped and flagged.
`timescale 1ns/1ps
`include "bridge_cfg.svh"

module bridge_discard_timer_ctrl #(
	parameter logic [15:0] LONG_PERIOD_CLKS = `DT_LONG_CLKS
) (
	input wire logic clk, // PCI clock
	input wire logic reset, // Async reset, active high
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic [7:0] cfg_addr, // Config byte address, dword aligned
	input wire logic [3:0] cfg_be, // Config byte enables
	input wire logic cfg_wr, // Config write strobe
	input wire logic cfg_rd, // Config read strobe
	input wire logic [31:0] cfg_wdata, // Config write data
	output logic [31:0] cfg_rdata, // Config read data
	output logic cfg_rvalid, // Read data valid pulse
	input wire logic [`DT_SLOTS-1:0] dc_head, // Completion reached queue head
	input wire logic [`DT_SLOTS-1:0] dc_done, // Retry received its completion
	output logic [`DT_SLOTS-1:0] dc_discard, // Drop the delayed transaction
	input wire logic conv_mode, // Conventional PCI mode
	input wire logic aer_present, // Advanced error reporting supported
	input wire logic aer_dt_mask, // Discard timer mask in error mask
	input wire logic aer_sev_fatal, // Severity chosen fatal
	output logic err_msg_req, // Error message pending
	output logic err_msg_fatal, // Pending message is fatal
	input wire logic err_msg_ack, // Upstream took the message
	input wire logic [`INTX_LINES-1:0] sec_int_n, // Secondary interrupt pins
	output logic [`INTX_LINES-1:0] up_int_assert // Interrupts forwarded upstream
);

	localparam logic [7:0] BRCTL_OFS = `CFG_BRCTL_OFS;
	localparam logic [7:0] INTPIN_OFS = `CFG_INTPIN_OFS;
	localparam logic [1:0] BRCTL_LANE = BRCTL_OFS[1:0];
	localparam logic [1:0] BRCTL_HI_LANE = BRCTL_OFS[1:0] + 2'h1;
	localparam logic [1:0] INTPIN_LANE = INTPIN_OFS[1:0];

	bridge_pkg::ctrl_state_t q;
	bridge_pkg::ctrl_state_t d;

	discard_if dif ();

	logic addr_hit;
	logic [15:0] brctl_view;
	logic [15:0] brctl_wr;
	logic [31:0] rd_word;
	logic [2:0] n_expired;
	logic any_expired;
	logic msg_allowed;
	logic [4:0] pend_sum;
	logic [4:0] pend_next;

	// All registers of this block live in one dword
	assign addr_hit = (cfg_addr[7:2] == BRCTL_OFS[7:2]);

	// Bridge control as software sees it
	always_comb
	begin
		brctl_view = `BRCTL_RESET;
		brctl_view[15:12] = `BRCTL_RSVD_VALUE;
		brctl_view[`BRCTL_ERRMSG_BIT] = q.errmsg_en;
		brctl_view[`BRCTL_DTSTAT_BIT] = q.discard_flag;
		brctl_view[`BRCTL_PERIOD_BIT] = q.period_sel;
	end

	// Assemble the whole dword
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_word[7:0] = `INTLINE_VALUE;
		rd_word[INTPIN_LANE*8 +: 8] = `INTPIN_VALUE;
		rd_word[BRCTL_LANE*8 +: 16] = brctl_view;
	end

	// Write data aligned to the bridge control field
	assign brctl_wr = cfg_wdata[BRCTL_LANE*8 +: 16];

	// Count expiries of this cycle
	always_comb
	begin
		n_expired = 3'h0;
		for (int i = 0; i < `DT_SLOTS; i++)
		begin
			if (dif.expired[i])
				n_expired = n_expired + 3'h1;
		end
	end

	assign any_expired = (n_expired != 3'h0);

	// Which paths may raise an error message
	always_comb
	begin
		msg_allowed = conv_mode && q.errmsg_en;
		if (aer_present && !aer_dt_mask)
			msg_allowed = 1'b1;
	end

	// Pending message count after adds and the take
	always_comb
	begin
		pend_sum = {1'b0, q.msg_pending};
		if (msg_allowed)
			pend_sum = pend_sum + {2'b00, n_expired};
		if (err_msg_ack && (q.msg_pending != 4'h0))
			pend_sum = pend_sum - 5'h01;
		if (pend_sum > {1'b0, `MSG_PEND_MAX})
			pend_next = {1'b0, `MSG_PEND_MAX};
		else
			pend_next = pend_sum;
	end

	// Next state of the control block
	always_comb
	begin
		d = q;
		d.rvalid = 1'b0;
		// Read answer, zero outside this dword
		if (cfg_rd)
		begin
			d.rvalid = 1'b1;
			d.rdata = addr_hit ? rd_word : 32'h0000_0000;
		end
		if (cfg_wr && addr_hit && cfg_be[BRCTL_HI_LANE])
		begin
			d.errmsg_en = brctl_wr[`BRCTL_ERRMSG_BIT];
			d.period_sel = brctl_wr[`BRCTL_PERIOD_BIT];
			if (brctl_wr[`BRCTL_DTSTAT_BIT])
				d.discard_flag = 1'b0;
		end
		if (any_expired)
			d.discard_flag = 1'b1;
		d.msg_pending = pend_next[3:0];
		if (q.msg_pending == 4'h0)
			d.msg_fatal = aer_present && aer_sev_fatal;
	end

	// State register, frozen while enable is low
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign dif.limit = q.period_sel ? `DT_SHORT_CLKS : LONG_PERIOD_CLKS;
	assign dif.ce = ce;

	// One timer per pending completion
	generate
		for (genvar g = 0; g < `DT_SLOTS; g++)
		begin : g_slot
			assign dif.start[g] = dc_head[g];
			assign dif.stop[g] = dc_done[g];
			assign dc_discard[g] = dif.expired[g];

			discard_slot_timer #(
				.IDX(g)
			) u_slot (
				.clk(clk),
				.reset(reset),
				.dif(dif.slot)
			);
		end
	endgenerate

	intx_sync u_intx (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.pins_n(sec_int_n),
		.level(up_int_assert)
	);

	// Register outputs
	assign cfg_rdata = q.rdata;
	assign cfg_rvalid = q.rvalid;
	assign err_msg_req = (q.msg_pending != 4'h0);
	assign err_msg_fatal = q.msg_fatal;

endmodule : bridge_discard_timer_ctrl

// [tb/bridge_props.sv]
`timescale 1ns/1ps
module bridge_props (
	input wire logic clk, // Clock
	input wire logic reset, // Reset
	input wire logic ce, // Enable
	input wire logic cfg_rd, // Read
	input wire logic [31:0] cfg_rdata, // Data
	input wire logic cfg_rvalid, // Valid
	input wire logic [3:0] dc_discard, // Drops
	input wire logic [3:0] dc_done, // Retries
	input wire logic err_msg_req, // Message
	input wire logic [3:0] sec_int_n, // Pins
	input wire logic [3:0] up_int_assert // Forwarded
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Slot stays silent after a retry
	sequence s_quiet;
		!dc_discard[0] [*4];
	endsequence
	// Register read path
	a_rd_answer: assert property (ce && cfg_rd |=> cfg_rvalid) else $error("read unanswered");
	a_rd_cause: assert property (cfg_rvalid |-> $past(cfg_rd)) else $error("stray valid");
	a_pin_zero: assert property (cfg_rvalid |-> cfg_rdata[15:0] == 16'h0000) else $error("pin byte set");
	a_rsvd_zero: assert property (cfg_rvalid |-> cfg_rdata[31:28] == 4'h0) else $error("reserved set");
	// Two-stage interrupt forwarding
	a_int_fwd: assert property (!$past(reset) && !$past(reset, 2) && $past(ce) && $past(ce, 2)
		|-> up_int_assert == ~$past(sec_int_n, 2)) else $error("int lost");
	// Drops and messages
	a_drop_pulse: assert property (dc_discard != 4'h0 |=> (dc_discard & $past(dc_discard)) == 4'h0)
		else $error("long drop");
	a_msg_cause: assert property ($rose(err_msg_req) |-> $past(dc_discard) != 4'h0) else $error("stray msg");
	a_retry_quiet: assert property (dc_done[0] |-> ##2 s_quiet) else $error("drop after retry");
endmodule : bridge_props

bind bridge_discard_timer_ctrl bridge_props i_bridge_props (.*);

// [tb/retry_master.sv]
`timescale 1ns/1ps
module retry_master (
	input wire logic clk, // Clock
	input wire logic [3:0] dc_head, // Completion ready
	input wire logic [15:0] delay, // Retry wait, zero never
	output logic [3:0] dc_done = 4'h0 // Retry served
);
	int cnt [4] = '{0, 0, 0, 0};
	always @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			dc_done[i] <= (cnt[i] == 1);
			if (dc_head[i])
				cnt[i] <= delay;
			else if (cnt[i] != 0)
				cnt[i] <= cnt[i] - 1;
		end
	end
endmodule : retry_master

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	localparam logic [15:0] LONG = 16'h0020;
	typedef struct {logic [7:0] a; logic [3:0] be; logic [31:0] w; logic [31:0] x;} row_t;
	logic clk = 1'b0, reset = 1'b1, ce = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, err_msg_ack = 1'b0;
	logic conv_mode = 1'b1, aer_present = 1'b0, aer_dt_mask = 1'b1, aer_sev_fatal = 1'b0;
	logic [7:0] cfg_addr = 8'h3c;
	logic [3:0] cfg_be = 4'h0, dc_head = 4'h0, sec_int_n = 4'hf;
	logic [31:0] cfg_wdata = 32'h0;
	logic [15:0] delay = 16'h0;
	logic [3:0] dc_done, dc_discard, up_int_assert;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid, err_msg_req, err_msg_fatal;
	int err_count = 0, n_compared = 0, n;
	row_t rows [5] = '{'{8'h3c, 4'hf, 32'hffff_ffff, 32'h0a00_0000}, '{8'h3c, 4'h7, 32'h0, 32'h0a00_0000},
		'{8'h3c, 4'h8, 32'h0800_0000, 32'h0800_0000}, '{8'h40, 4'hf, 32'hffff_ffff, 32'h0},
		'{8'h3c, 4'h8, 32'h0, 32'h0}};

	bridge_discard_timer_ctrl #(.LONG_PERIOD_CLKS(LONG)) i_bridge_discard_timer_ctrl (.*);
	retry_master i_retry_master (.*);

	// Free-running clock
	initial
		forever #2 clk = ~clk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] w);
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= w;
		cfg_wr <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] x);
		cfg_addr <= a;
		cfg_rd <= 1'b1;
		@(posedge clk);
		cfg_rd <= 1'b0;
		@(posedge clk);
		chk(32'(cfg_rvalid), 32'h1);
		chk(cfg_rdata, x);
	endtask : rd

	// Start a slot timer and count cycles to its drop
	task expire(input int s, input int x);
		dc_head[s] <= 1'b1;
		@(posedge clk);
		dc_head[s] <= 1'b0;
		n = -1;
		while (n < 2000 && dc_discard[s] !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(n), 32'(x));
		@(posedge clk);
	endtask : expire

	// Acknowledge pending messages on alternate cycles
	task drain;
		repeat (40)
		begin
			@(posedge clk);
			err_msg_ack <= err_msg_req && !err_msg_ack;
		end
		chk(32'(err_msg_req), 32'h0);
	endtask : drain

	task complete_run;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(8'h3c, 32'h0);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].be, rows[i].w);
			rd(rows[i].a, rows[i].x);
		end
		wr(8'h3c, 4'h8, 32'h0800_0000);
		expire(0, LONG);
		chk(32'({err_msg_req, err_msg_fatal}), 32'h2);
		rd(8'h3c, 32'h0c00_0000);
		wr(8'h3c, 4'h8, 32'h0e00_0000);
		rd(8'h3c, 32'h0a00_0000);
		drain;
		expire(1, 1024);
		drain;
		conv_mode <= 1'b0;
		expire(2, 1024);
		chk(32'(err_msg_req), 32'h0);
		{aer_present, aer_dt_mask, aer_sev_fatal} <= 3'b101;
		wr(8'h3c, 4'h8, 32'h0400_0000);
		expire(3, LONG);
		chk(32'({err_msg_req, err_msg_fatal}), 32'h3);
		drain;
		aer_dt_mask <= 1'b1;
		expire(0, LONG);
		chk(32'(err_msg_req), 32'h0);
		delay <= 16'h0005;
		expire(0, 2000);
		sec_int_n <= 4'h5;
		repeat (3) @(posedge clk);
		chk(32'(up_int_assert), 32'ha);
		// Enable low freezes read answer and forwarding
		ce <= 1'b0;
		sec_int_n <= 4'hf;
		cfg_rd <= 1'b1;
		@(posedge clk);
		cfg_rd <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'({cfg_rvalid, up_int_assert}), 32'h0a);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(up_int_assert), 32'h0);
		// Reset in mid-run drops flag and pending message
		{conv_mode, delay} <= {1'b1, 16'h0000};
		wr(8'h3c, 4'h8, 32'h0800_0000);
		expire(1, LONG);
		chk(32'(err_msg_req), 32'h1);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(8'h3c, 32'h0);
		chk(32'(err_msg_req), 32'h0);
		complete_run;
	end

	// Hang guard
	initial
	begin
		#100000;
		err_count++;
		complete_run;
	end
endmodule : tb
